// file: sess_pkg.sv
package sess_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int WRITE_TIME_US = 5000;
   localparam int WRITE_CYCLES  = (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_CLEAR_SRAM   = 8'h11;
   localparam logic [7:0] OP_STATUS_READ  = 8'h12;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h13;
   localparam logic [7:0] OP_LATCH_SET    = 8'h14;
   localparam logic [7:0] OP_LATCH_CLEAR  = 8'h15;
   localparam logic [7:0] OP_LATCH_ALIAS  = 8'h16;
   localparam logic [7:0] OP_NV_READ      = 8'h17;
   localparam logic [7:0] OP_NV_WRITE     = 8'h18;
   localparam logic [7:0] CMD_NONE        = 8'h00;

   // ---------------------------------------------------------------
   // status byte layout and block protection
   // ---------------------------------------------------------------
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_LATCH_BIT = 1;
   localparam int ST_BP_LSB    = 2;
   localparam int ST_BP_MSB    = 3;
   localparam logic [3:0] ST_HIGH_ZERO = 4'h0;
   localparam logic [1:0] BP_NONE      = 2'h0;
   localparam logic [1:0] BP_QUARTER   = 2'h1;
   localparam logic [1:0] BP_HALF      = 2'h2;
   localparam logic [1:0] BP_RESET     = 2'h0;

   // ---------------------------------------------------------------
   // array geometry
   // ---------------------------------------------------------------
   localparam int NV_ADDR_W  = 8;
   localparam int PAGE_BITS  = 3;
   localparam int PAGE_BYTES = 8;
   localparam logic [7:0] TX_IDLE = 8'h00;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_OPC    = 5'b00010,
      ST_ADDR   = 5'b00100,
      ST_DATA   = 5'b01000,
      ST_IGNORE = 5'b10000
   } sess_state_t;

endpackage

// file: sess_mem.sv
`timescale 1ns/1ps
module sess_mem #(
   parameter int DW = 8,
   parameter int AW = 8
) (
   // clock and reset
   input  wire logic          clock,
   input  wire logic          rst_n,
   // write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // read port
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [DW-1:0] cells [2**AW];

   // array contents are nonvolatile, so no reset on the cells
   always_ff @(posedge clock) begin
      if (wr_en) begin
         cells[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= cells[rd_addr];
      end
   end

endmodule

// file: sess_top.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE1] clear-sram command zeroes all sram, timekeeping untouched; done by a clear pulse
// [RULE2] clear-sram is opcode plus one ignored dummy byte, then select release
// [RULE3] block-protect 00 none, 01 upper quarter, 10 upper half, 11 whole array
// [RULE4] block-protect bits kept nonvolatile, changed only by a status write; here bp also returns to BP_RESET at reset
// [RULE5] status bit 1 shows write latch; set/cleared by commands; blocks writes
// [RULE6] status bit 0 is busy, high only while a write cycle runs
// [RULE7] write latch clears itself when a write cycle finishes
// [RULE8] latch set takes effect only when select rises after eight bits
// [RULE9] status write is opcode plus one byte; cycle starts at select release
// [RULE10] status read shifts status out, accepted any time, even while busy
// [RULE11] latch cleared at reset, after latch clear, writes, failed unlock sequences
// [RULE12] array read streams bytes from address, incrementing, wrapping to zero
// [RULE13] host sets latch first, then writes at most one page
// [RULE14] page write address advances only in low three bits, wrapping
// [RULE15] write commits only if select rises right after a complete byte
// [RULE16] array reads refused during a write cycle; status reads still work
// [RULE17] host should poll busy through status reads
// [RULE18] sram and clock commands stay usable right after a write starts
// [RULE19] writes to a protected region start no cycle and change nothing
// [RULE20] command codes and spi mode come from a shared command table
// [RULE21] status bits 7 to 4 always read zero
module sess_top #(
   parameter int ADDR_W       = sess_pkg::NV_ADDR_W,
   parameter int WRITE_CYCLES = sess_pkg::WRITE_CYCLES
) (
   // core clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // spi link
   input  wire logic spi_sclk,
   input  wire logic cs_n,
   input  wire logic mosi,
   output logic      so_out,
   output logic      so_oe,
   // shared with neighbouring logic
   input  wire logic prot_latch_clear,
   output logic      write_latch_flag,
   output logic      write_busy_flag,
   output logic      sram_clear
);

   localparam int CW = (WRITE_CYCLES > 15) ? $clog2(WRITE_CYCLES + 1) : 4;
   localparam int PB = sess_pkg::PAGE_BITS;

   // ---------------------------------------------------------------
   // link side, clocked by the serial clock
   // ---------------------------------------------------------------
   logic             link_rst_n;
   logic [2:0]       bit_cnt;
   logic [6:0]       rx_shift;
   logic [7:0]       rx_byte;
   logic             rx_tgl;
   logic             frag;
   logic [7:0]       tx_hold;
   logic [7:0]       tx_shift;
   logic [7:0]       tx_byte;

   // deselect clears the bit position, so every frame starts byte aligned
   assign link_rst_n = rst_n & ~cs_n;

   always_ff @(posedge spi_sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt  <= 3'h0;
         rx_shift <= 7'h00;
      end else begin
         bit_cnt  <= bit_cnt + 3'h1;
         rx_shift <= {rx_shift[5:0], mosi};
      end
   end

   // tx_byte only moves while cs_s2 is high or shortly after a byte toggle, so it is quiet here
   always_ff @(posedge spi_sclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_byte <= 8'h00;
         rx_tgl  <= 1'b0;
         frag    <= 1'b0;
         tx_hold <= 8'h00;
      end else begin
         frag <= (bit_cnt != 3'h7);
         if (bit_cnt == 3'h7) begin
            rx_byte <= {rx_shift, mosi};
            rx_tgl  <= ~rx_tgl;
            tx_hold <= tx_byte;
         end
      end
   end

   // [RULE10] serial output shift
   always_ff @(negedge spi_sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_shift <= 8'h00;
         so_out   <= 1'b0;
         so_oe    <= 1'b0;
      end else begin
         so_oe <= 1'b1;
         if (bit_cnt == 3'h0) begin
            so_out   <= tx_hold[7];
            tx_shift <= {tx_hold[6:0], 1'b0};
         end else begin
            so_out   <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
         end
      end
   end

   AST_SO_DRIVEN_IN_FRAME: assert property ( // [RULE10]
      @(posedge spi_sclk) disable iff (!link_rst_n) (bit_cnt > 3'h1) |-> so_oe)
      else $error("serial output not driven inside a frame");

   // ---------------------------------------------------------------
   // crossing into the core clock
   // ---------------------------------------------------------------
   logic cs_s1, cs_s2, cs_s3, cs_s4;
   logic tg_s1, tg_s2, tg_s3;
   logic fr_s1, fr_s2;
   logic rx_ev;
   logic cs_low;
   logic cs_end;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {cs_s1, cs_s2, cs_s3, cs_s4} <= 4'hF;
         {tg_s1, tg_s2, tg_s3}        <= 3'h0;
         {fr_s1, fr_s2}               <= 2'h0;
      end else begin
         {cs_s1, cs_s2, cs_s3, cs_s4} <= {cs_n, cs_s1, cs_s2, cs_s3};
         {tg_s1, tg_s2, tg_s3}        <= {rx_tgl, tg_s1, tg_s2};
         {fr_s1, fr_s2}               <= {frag, fr_s1};
      end
   end

   // frame end is one cycle late so a last byte is always seen first
   assign rx_ev  = tg_s2 ^ tg_s3;
   assign cs_low = ~cs_s2;
   assign cs_end = cs_s3 & ~cs_s4;

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   sess_pkg::sess_state_t state, next_state;
   logic [7:0]        cmd;
   logic [3:0]        bcnt;
   logic [ADDR_W-1:0] ptr;
   logic [ADDR_W-1:0] rd_addr;
   logic [7:0]        rd_data;
   logic              rd_en, rd_pend;
   logic              op_sr, op_sw, op_cs, op_set, op_clr, op_rd, op_nw, op_known;
   logic              cmd_sr, cmd_sw, cmd_cs, cmd_set, cmd_clr, cmd_rd, cmd_nw;
   logic              in_opc, in_addr, in_data, clean;
   logic [7:0]        status_byte;
   logic [1:0]        bp;

   // [RULE20] codes from the shared table
   assign op_sr    = rx_byte == sess_pkg::OP_STATUS_READ;
   assign op_sw    = rx_byte == sess_pkg::OP_STATUS_WRITE;
   assign op_cs    = rx_byte == sess_pkg::OP_CLEAR_SRAM;
   assign op_set   = rx_byte == sess_pkg::OP_LATCH_SET;
   assign op_clr   = (rx_byte == sess_pkg::OP_LATCH_CLEAR) | (rx_byte == sess_pkg::OP_LATCH_ALIAS);
   assign op_rd    = rx_byte == sess_pkg::OP_NV_READ;
   assign op_nw    = rx_byte == sess_pkg::OP_NV_WRITE;
   assign op_known = op_sr | op_sw | op_cs | op_set | op_clr | op_rd | op_nw;
   assign cmd_sr   = cmd == sess_pkg::OP_STATUS_READ;
   assign cmd_sw   = cmd == sess_pkg::OP_STATUS_WRITE;
   assign cmd_cs   = cmd == sess_pkg::OP_CLEAR_SRAM;
   assign cmd_set  = cmd == sess_pkg::OP_LATCH_SET;
   assign cmd_clr  = (cmd == sess_pkg::OP_LATCH_CLEAR) | (cmd == sess_pkg::OP_LATCH_ALIAS);
   assign cmd_rd   = cmd == sess_pkg::OP_NV_READ;
   assign cmd_nw   = cmd == sess_pkg::OP_NV_WRITE;
   assign in_opc   = state == sess_pkg::ST_OPC;
   assign in_addr  = state == sess_pkg::ST_ADDR;
   assign in_data  = state == sess_pkg::ST_DATA;
   // [RULE15] select rose on a byte boundary
   assign clean    = ~fr_s2;

   // [RULE21] upper status bits zero
   assign status_byte = {sess_pkg::ST_HIGH_ZERO, bp, write_latch_flag, write_busy_flag};

   always_comb begin
      next_state = state;
      case (state)
         sess_pkg::ST_IDLE: begin
            if (cs_low) begin
               next_state = sess_pkg::ST_OPC;
            end
         end
         sess_pkg::ST_OPC: begin
            // [RULE16] array access refused while busy
            if (rx_ev && !op_known) begin
               next_state = sess_pkg::ST_IGNORE;
            end else if (rx_ev && (op_rd || op_nw)) begin
               next_state = write_busy_flag ? sess_pkg::ST_IGNORE : sess_pkg::ST_ADDR;
            end else if (rx_ev) begin
               next_state = sess_pkg::ST_DATA;
            end
         end
         sess_pkg::ST_ADDR: begin
            if (rx_ev) begin
               next_state = sess_pkg::ST_DATA;
            end
         end
         sess_pkg::ST_DATA: begin
            next_state = sess_pkg::ST_DATA;
         end
         sess_pkg::ST_IGNORE: begin
            next_state = sess_pkg::ST_IGNORE;
         end
         default: begin
            next_state = sess_pkg::ST_IDLE;
         end
      endcase
      if (cs_end) begin
         next_state = sess_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= sess_pkg::ST_IDLE;
         cmd   <= sess_pkg::CMD_NONE;
         bcnt  <= 4'h0;
      end else begin
         state <= next_state;
         if (cs_end || state == sess_pkg::ST_IDLE) begin
            cmd  <= sess_pkg::CMD_NONE;
            bcnt <= 4'h0;
         end else if (rx_ev) begin
            cmd  <= in_opc ? rx_byte : cmd;
            bcnt <= (bcnt == 4'hF) ? bcnt : bcnt + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // array read stream and page buffer
   // ---------------------------------------------------------------
   logic [7:0]           pbuf [sess_pkg::PAGE_BYTES];
   logic [7:0]           pvalid;
   logic [ADDR_W-PB-1:0] wpage;
   logic                 buf_wr;
   logic                 buf_clr;
   logic [1:0]           sw_bp;

   // [RULE12] read address source
   assign rd_en   = rx_ev & cmd_rd & (in_addr | in_data);
   assign rd_addr = in_addr ? rx_byte[ADDR_W-1:0] : ptr;
   assign buf_wr  = rx_ev & in_data & cmd_nw;
   assign buf_clr = rx_ev & in_opc & op_nw & ~write_busy_flag;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ptr     <= '0;
         rd_pend <= 1'b0;
         sw_bp   <= sess_pkg::BP_RESET;
      end else begin
         rd_pend <= rd_en;
         // [RULE12] increment and wrap
         if (rd_en) begin
            ptr <= rd_addr + ADDR_W'(1);
         end else if (rx_ev && in_addr) begin
            ptr <= rx_byte[ADDR_W-1:0];
         // [RULE14] wrap inside the page
         end else if (buf_wr) begin
            ptr <= {ptr[ADDR_W-1:PB], ptr[PB-1:0] + PB'(1)};
         end
         // [RULE9] status write data byte, protect bits captured
         if (rx_ev && in_data && cmd_sw && bcnt == 4'h1) begin
            sw_bp <= rx_byte[sess_pkg::ST_BP_MSB:sess_pkg::ST_BP_LSB];
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < sess_pkg::PAGE_BYTES; gi++) begin : g_page
         // [RULE14] later bytes overwrite earlier
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               pbuf[gi]   <= 8'h00;
               pvalid[gi] <= 1'b0;
            end else if (buf_clr) begin
               pvalid[gi] <= 1'b0;
            end else if (buf_wr && ptr[PB-1:0] == PB'(gi)) begin
               pbuf[gi]   <= rx_byte;
               pvalid[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   AST_PAGE_STAYS: assert property ( // [RULE14]
      @(posedge clock) disable iff (!rst_n)
      buf_wr |=> ptr[ADDR_W-1:PB] == $past(ptr[ADDR_W-1:PB]))
      else $error("page write left its page");

   // [RULE10] status answer; array bytes trail one slot
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_byte <= sess_pkg::TX_IDLE;
      end else if (cs_s2) begin
         tx_byte <= status_byte;
      end else if (rd_pend) begin
         tx_byte <= rd_data;
      end else if (rx_ev) begin
         tx_byte <= ((in_opc && op_sr) || (in_data && cmd_sr)) ? status_byte : sess_pkg::TX_IDLE;
      end
   end

   AST_READ_NOT_BUSY: assert property ( // [RULE16]
      @(posedge clock) disable iff (!rst_n) rd_en |-> !write_busy_flag)
      else $error("array read issued during a write cycle");

   // ---------------------------------------------------------------
   // frame end actions
   // ---------------------------------------------------------------
   logic do_set, do_clr, do_sw, do_nw, do_cs, page_prot;

   function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic [1:0] b);
      case (b)
         sess_pkg::BP_NONE:    prot_hit = 1'b0;
         sess_pkg::BP_QUARTER: prot_hit = a[ADDR_W-1] & a[ADDR_W-2];
         sess_pkg::BP_HALF:    prot_hit = a[ADDR_W-1];
         default:              prot_hit = 1'b1;
      endcase
   endfunction

   // [RULE3] region test on the page
   assign page_prot = prot_hit({ptr[ADDR_W-1:PB], PB'(0)}, bp);
   // [RULE8] latch set on release only
   assign do_set = cs_end & cmd_set & (bcnt == 4'h1) & clean & ~write_busy_flag;
   assign do_clr = cs_end & cmd_clr & (bcnt == 4'h1) & clean & ~write_busy_flag;
   // [RULE9] status write on release
   assign do_sw  = cs_end & cmd_sw & (bcnt == 4'h2) & clean & write_latch_flag & ~write_busy_flag;
   // [RULE19] protected pages ignored
   assign do_nw  = cs_end & cmd_nw & in_data & (bcnt > 4'h2) & clean & write_latch_flag
                   & ~write_busy_flag & ~page_prot & (|pvalid);
   // [RULE2] exactly one dummy byte
   assign do_cs  = cs_end & cmd_cs & (bcnt == 4'h2) & clean;

   // [RULE1] sram clear request pulse
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sram_clear <= 1'b0;
      end else begin
         sram_clear <= do_cs;
      end
   end

   AST_SRAM_CLEAR_ONCE: assert property ( // [RULE1]
      @(posedge clock) disable iff (!rst_n) sram_clear |-> $past(cs_end) && !$past(sram_clear))
      else $error("sram clear not a single pulse at frame end");

   // ---------------------------------------------------------------
   // nonvolatile write cycle
   // ---------------------------------------------------------------
   logic [CW-1:0] wtimer;
   logic          wkind_sw;
   logic          wr_last;
   logic          mem_we;
   logic [ADDR_W-1:0] mem_wa;

   assign wr_last = write_busy_flag & (wtimer == CW'(WRITE_CYCLES - 1));
   assign mem_we  = write_busy_flag & ~wkind_sw & (wtimer < CW'(sess_pkg::PAGE_BYTES))
                    & pvalid[wtimer[PB-1:0]];
   assign mem_wa  = {wpage, wtimer[PB-1:0]};

   // [RULE6] busy spans the whole cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         write_busy_flag <= 1'b0;
         wtimer          <= '0;
         wkind_sw        <= 1'b0;
         wpage           <= '0;
      end else if (do_sw || do_nw) begin
         write_busy_flag <= 1'b1;
         wtimer          <= '0;
         wkind_sw        <= do_sw;
         wpage           <= ptr[ADDR_W-1:PB];
      end else if (wr_last) begin
         write_busy_flag <= 1'b0;
      end else if (write_busy_flag) begin
         wtimer <= wtimer + CW'(1);
      end
   end

   // [RULE4] protect bits move only at status write end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bp <= sess_pkg::BP_RESET;
      end else if (wr_last && wkind_sw) begin
         bp <= sw_bp;
      end
   end

   // [RULE5] latch set and cleared; [RULE7] [RULE11] auto clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         write_latch_flag <= 1'b0;
      end else if (do_set) begin
         write_latch_flag <= 1'b1;
      end else if (do_clr || wr_last || prot_latch_clear) begin
         write_latch_flag <= 1'b0;
      end
   end

   // [RULE18] array writes never stall the link
   sess_mem #(
      .DW (8),
      .AW (ADDR_W)
   ) u_array (
      .clock   (clock),
      .rst_n   (rst_n),
      .wr_en   (mem_we),
      .wr_addr (mem_wa),
      .wr_data (pbuf[wtimer[PB-1:0]]),
      .rd_en   (rd_en),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_BUSY_CLEARS_LATCH: assert property ( // [RULE7]
      @(posedge clock) disable iff (!rst_n) $fell(write_busy_flag) |-> !write_latch_flag)
      else $error("latch still set after a write cycle");

   AST_LATCH_AT_RELEASE: assert property ( // [RULE8]
      @(posedge clock) disable iff (!rst_n) $rose(write_latch_flag) |-> $past(cs_end) && $past(cmd_set))
      else $error("latch set away from a latch-set frame end");

   AST_WRITE_NEEDS_LATCH: assert property ( // [RULE5]
      @(posedge clock) disable iff (!rst_n) $rose(write_busy_flag) |-> $past(write_latch_flag) && $past(clean))
      else $error("write cycle started without latch or on a broken byte");

   AST_BUSY_HOLDS: assert property ( // [RULE6]
      @(posedge clock) disable iff (!rst_n) $rose(write_busy_flag) |-> write_busy_flag [*8])
      else $error("busy dropped early");

   AST_BP_SOURCE: assert property ( // [RULE4]
      @(posedge clock) disable iff (!rst_n) $changed(bp) |-> $past(wr_last) && $past(wkind_sw))
      else $error("protect bits changed outside a status write");

   AST_NO_PROT_WRITE: assert property ( // [RULE19]
      @(posedge clock) disable iff (!rst_n) mem_we |-> !prot_hit(mem_wa, bp))
      else $error("array write into a protected region");

   AST_STATUS_UPPER: assert property ( // [RULE21]
      @(posedge clock) disable iff (!rst_n) (cs_s2 || rx_ev) |=> tx_byte[7:4] == 4'h0 || rd_pend)
      else $error("status upper bits not zero");

endmodule

// file: sess_host.sv
`timescale 1ns/1ps
module sess_host (
   // link pins
   output logic      spi_sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic so_out
);
   logic [7:0] tx [16];
   logic [7:0] rx [16];
   initial begin
      spi_sclk = 1'b0;
      cs_n     = 1'b1;
      mosi     = 1'b0;
   end
   // nbits serial clocks, whole bytes or not, then release
   // clock stands low between frames; the gap covers the 300 ns minimum
   task automatic frame(input int nbits);
      int i;
      cs_n = 1'b0;
      for (i = 0; i < nbits; i++) begin
         mosi = tx[i/8][7-i%8];
         #80 spi_sclk = 1'b1;
         rx[i/8][7-i%8] = so_out;
         #80 spi_sclk = 1'b0;
      end
      #100 cs_n = 1'b1;
      mosi = ~mosi;
      #400;
   endtask
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
   // ----
   // signals
   // ----
   logic       clock;
   logic       rst_n;
   logic       spi_sclk;
   logic       cs_n;
   logic       mosi;
   logic       so_out;
   logic       so_oe;
   logic       prot_latch_clear;
   logic       write_latch_flag;
   logic       write_busy_flag;
   logic       sram_clear;
   logic [7:0] exp_mem [256];
   logic [7:0] a;
   int         failures;
   int         samples_checked;
   int         seed;
   int         pulses;
   int         j;
   int         k;
   int         rises;

   // write time cut to 200 cycles, still long enough that a status read lands inside the busy window
   sess_top #(.WRITE_CYCLES(200)) dut (.clock(clock), .rst_n(rst_n), .spi_sclk(spi_sclk), .cs_n(cs_n),
      .mosi(mosi), .so_out(so_out), .so_oe(so_oe), .prot_latch_clear(prot_latch_clear),
      .write_latch_flag(write_latch_flag), .write_busy_flag(write_busy_flag), .sram_clear(sram_clear));
   sess_host host (.spi_sclk(spi_sclk), .cs_n(cs_n), .mosi(mosi), .so_out(so_out));

   // ----
   // helpers
   // ----
   function automatic logic [7:0] st(input logic [1:0] bp, input logic wl, input logic wb);
      return {sess_pkg::ST_HIGH_ZERO, bp, wl, wb};
   endfunction
   function automatic logic [7:0] page_slot(input logic [7:0] ad, input int n);
      logic [2:0] o;
      o = ad[2:0] + n[2:0];
      return {ad[7:3], o};
   endfunction
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, input int nbits);
      @(negedge clock);
      host.tx[0] = b0;
      host.tx[1] = b1;
      host.frame(nbits);
   endtask
   task automatic status(input logic [7:0] exp);
      xfer(sess_pkg::OP_STATUS_READ, 8'h00, 16);
      check("status", exp, host.rx[1]);
   endtask
   // polls busy, bounded, then checks the settled status
   task automatic settle(input logic [7:0] exp);
      int n;
      xfer(sess_pkg::OP_STATUS_READ, 8'h00, 16);
      for (n = 0; n < 20 && host.rx[1][0] !== 1'b0; n++) xfer(sess_pkg::OP_STATUS_READ, 8'h00, 16);
      check("status", exp, host.rx[1]);
   endtask
   task automatic conclude;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ----
   // clock, monitors, watchdog
   // ----
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) if (sram_clear === 1'b1) pulses++;
   // output enable must be up from the second serial clock of a frame
   always @(negedge cs_n) rises = 0;
   always @(posedge spi_sclk) begin
      if (rises > 0) check("so_oe", 8'h01, {7'h00, so_oe});
      rises++;
   end
   initial begin
      #1000000;
      failures++;
      conclude();
   end

   // ----
   // main sequence
   // ----
   initial begin
      seed = 951;
      failures = 0;
      samples_checked = 0;
      pulses = 0;
      prot_latch_clear = 1'b0;
      rst_n = 1'b0;
      repeat (5) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      check("so_oe", 8'h00, {7'h00, so_oe});
      status(st(2'h0, 1'b0, 1'b0));
      xfer(sess_pkg::OP_LATCH_SET, sess_pkg::OP_NV_WRITE, 16);
      check("latch", 8'h00, {7'h00, write_latch_flag});
      for (k = 0; k < 2; k++) begin
         xfer(sess_pkg::OP_LATCH_SET, 8'h00, 8);
         status(st(2'h0, 1'b1, 1'b0));
         xfer(k ? sess_pkg::OP_LATCH_ALIAS : sess_pkg::OP_LATCH_CLEAR, 8'h00, 8);
         check("latch", 8'h00, {7'h00, write_latch_flag});
      end
      for (k = 0; k < 2; k++) begin
         a = k ? 8'h06 : 8'hFE;
         xfer(sess_pkg::OP_LATCH_SET, 8'h00, 8);
         host.tx[0] = sess_pkg::OP_NV_WRITE;
         host.tx[1] = a;
         for (j = 0; j < 3; j++) begin
            host.tx[2+j] = 8'($random(seed));
            exp_mem[page_slot(a, j)] = host.tx[2+j];
         end
         @(negedge clock);
         host.frame(40);
         status(st(2'h0, 1'b1, 1'b1));
         // array read inside the busy window must come back empty
         xfer(sess_pkg::OP_NV_READ, a, 32);
         check("read_busy", 8'h00, host.rx[3]);
         settle(st(2'h0, 1'b0, 1'b0));
      end
      host.tx[0] = sess_pkg::OP_NV_READ;
      host.tx[1] = 8'hFE;
      host.frame(48);
      for (j = 0; j < 3; j++) check("read", exp_mem[8'hFE + j[7:0]], host.rx[3+j]);
      xfer(sess_pkg::OP_LATCH_SET, 8'h00, 8);
      // one whole data byte then half a byte, so the cut byte aborts the whole write
      xfer(sess_pkg::OP_NV_WRITE, 8'h10, 28);
      status(st(2'h0, 1'b1, 1'b0));
      xfer(sess_pkg::OP_STATUS_WRITE, 8'hF5, 16);
      settle(st(sess_pkg::BP_QUARTER, 1'b0, 1'b0));
      for (k = 0; k < 2; k++) begin
         xfer(sess_pkg::OP_LATCH_SET, 8'h00, 8);
         host.tx[2] = 8'($random(seed));
         xfer(sess_pkg::OP_NV_WRITE, k ? 8'hBF : 8'hC0, 24);
         status(st(sess_pkg::BP_QUARTER, 1'b1, k[0]));
         // a refused write leaves the latch set
         settle(st(sess_pkg::BP_QUARTER, ~k[0], 1'b0));
      end
      xfer(sess_pkg::OP_CLEAR_SRAM, 8'($random(seed)), 16);
      check("sram_clear", 8'h01, pulses[7:0]);
      xfer(sess_pkg::OP_LATCH_SET, 8'h00, 8);
      @(negedge clock);
      prot_latch_clear = 1'b1;
      @(negedge clock);
      prot_latch_clear = 1'b0;
      repeat (3) @(negedge clock);
      check("latch", 8'h00, {7'h00, write_latch_flag});
      conclude();
   end
endmodule
